/* logic/dvrc_top.sv */
// Velocity reference control: command word decode, reference combination,
// minimum clamp, ramp control and report word.
// Assumes command and settings come from logic on the same clock; fault,
// warning and limit flags are pins and are synchronised here.
// Operation
// - Bus-only source clamps bus reference to minimum
// - Zero reference takes last nonzero sign
// - After reset clamp to positive minimum
// - Sum source sign follows signed sum
// - Expose internal, bus and ramp-input values
// - Shortened 0000 then 000F accepted only without position config
// - Mode bits honoured only in position config
// - Mode selector 2 is velocity, default 2
// - Report bits 0-6 give drive state, bit 7 warning
// - Bits 9, 11, 15 remote, limit, second_warning_flag
// - Bit 4 chooses ramp or special source
// - Special zero setting forces ramp output
// - Bit 5 low freezes ramp
// - Bit 6 low feeds zero reference
// - Bit 8 halts axis, stays enabled
// - Source setting 1 internal, 2 bus, 3 sum
// - Without position config mode fixed velocity
// - Halt uses direction deceleration ramp
`timescale 1ns/100ps
`default_nettype none
module dvrc_top
(
  input  wire logic                                   clk_sys_in,
  input  wire logic                                   rst_in,
  input  wire logic                                   cmd_wr_in,
  input  wire logic        [dvrc_pkg::DVRC_WORD_W-1:0] cmd_wdata_in,
  input  wire logic                                   mode_wr_in,
  input  wire logic        [7:0]                      mode_wdata_in,
  input  wire logic                                   pos_config_in,
  input  wire logic                                   remote_in,
  input  wire logic        [1:0]                      ramp_src_in,
  input  wire logic        [3:0]                      sfg_sel_in,
  input  wire logic signed [dvrc_pkg::DVRC_REF_W-1:0] int_ref_in,
  input  wire logic signed [dvrc_pkg::DVRC_REF_W-1:0] bus_ref_in,
  input  wire logic signed [dvrc_pkg::DVRC_REF_W-1:0] bus_target_speed_in,
  input  wire logic signed [dvrc_pkg::DVRC_REF_W-1:0] special_ref_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] min_freq_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] acc_cw_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] acc_acw_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] dec_cw_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] dec_acw_in,
  input  wire logic                                   fault_pin_in,
  input  wire logic                                   warn_pin_in,
  input  wire logic                                   second_warning_flag_pin_in,
  input  wire logic                                   limit_pin_in,
  output var  logic        [dvrc_pkg::DVRC_WORD_W-1:0] drive_command_word_out,
  output var  logic        [dvrc_pkg::DVRC_WORD_W-1:0] drive_state_report_word_out,
  output var  logic        [7:0]                      operating_mode_selector_out,
  output var  logic signed [dvrc_pkg::DVRC_REF_W-1:0] int_ref_act_out,
  output var  logic signed [dvrc_pkg::DVRC_REF_W-1:0] bus_ref_act_out,
  output var  logic signed [dvrc_pkg::DVRC_REF_W-1:0] ramp_in_act_out,
  output var  logic signed [dvrc_pkg::DVRC_REF_W-1:0] speed_ref_out
);
  import dvrc_pkg::*;

  typedef struct packed
  {
    logic [DVRC_WORD_W-1:0]        cw;
    logic [DVRC_WORD_W-1:0]        sw;
    logic [7:0]                    mode;
    dvrc_state_t                   st;
    logic                          neg_sign;
    logic [3:0]                    sync0;
    logic [3:0]                    sync1;
    logic [3:0]                    sync2;
    logic [3:0]                    flags;
    logic signed [DVRC_REF_W-1:0]  int_act;
    logic signed [DVRC_REF_W-1:0]  bus_act;
    logic signed [DVRC_REF_W-1:0]  ramp_act;
    logic signed [DVRC_REF_W-1:0]  speed;
  } dvrc_top_t;

  dvrc_top_t                     cur_ff;
  dvrc_top_t                     nxt_cur;
  logic signed [DVRC_REF_W-1:0]  ramp_value;
  logic signed [DVRC_REF_W-1:0]  ramp_target;
  logic        [DVRC_REF_W-1:0]  rate_up;
  logic        [DVRC_REF_W-1:0]  rate_dn;
  logic                          ramp_run;
  logic                          mode_bits_on;
  logic                          op_enabled;
  logic                          halt_req;

  // Mode-specific bits only act in the position configuration, velocity mode
  assign mode_bits_on = pos_config_in && (cur_ff.mode == DVRC_MODE_VEL);
  assign op_enabled   = (cur_ff.st == DVRC_ST_OPEN);
  // Halt is a mode bit too, so it is inert outside the position setup
  assign halt_req     = mode_bits_on && cur_ff.cw[DVRC_CW_HALT];

  always_comb
  begin
    logic turn_acw;
    turn_acw    = 1'b0;
    ramp_target = DVRC_REF_ZERO;
    ramp_run    = 1'b1;
    rate_up     = acc_cw_in;
    rate_dn     = dec_cw_in;
    if (!op_enabled || halt_req)
    begin
      // Halt keeps operation enabled but brakes on the direction ramp
      ramp_target = DVRC_REF_ZERO;
      ramp_run    = 1'b1;
    end
    else if (mode_bits_on)
    begin
      if (cur_ff.cw[DVRC_CW_USEREF])
        ramp_target = bus_target_speed_in;
      else
        ramp_target = DVRC_REF_ZERO;
      ramp_run = cur_ff.cw[DVRC_CW_UNLOCK];
    end
    else
    begin
      ramp_target = cur_ff.ramp_act;
    end
    // At standstill the target gives the direction, else the present speed
    if (ramp_value == DVRC_REF_ZERO)
      turn_acw = ramp_target[DVRC_REF_W-1];
    else
      turn_acw = ramp_value[DVRC_REF_W-1];
    if (turn_acw)
    begin
      rate_up = acc_acw_in;
      rate_dn = dec_acw_in;
    end
  end

  dvrc_ramp u_ramp
  (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (ramp_run),
    .target_in  (ramp_target),
    .rate_up_in (rate_up),
    .rate_dn_in (rate_dn),
    .value_out  (ramp_value)
  );

  always_comb
  begin
    logic signed [DVRC_REF_W-1:0] mag_min;
    logic signed [DVRC_REF_W-1:0] bus_abs;
    logic signed [DVRC_REF_W-1:0] bus_cl;
    logic                         sgn;
    logic                         use_special;
    mag_min     = DVRC_REF_W'(min_freq_in);
    bus_abs     = '0;
    bus_cl      = '0;
    sgn         = 1'b0;
    use_special = 1'b0;
    nxt_cur     = cur_ff;
    // Pins pass three stages; a change counts once stages two and three agree
    nxt_cur.sync0 = {fault_pin_in, warn_pin_in, second_warning_flag_pin_in, limit_pin_in};
    nxt_cur.sync1 = cur_ff.sync0;
    nxt_cur.sync2 = cur_ff.sync1;
    for (int i = 0; i < 4; i++)
    begin
      if (cur_ff.sync1[i] == cur_ff.sync2[i])
        nxt_cur.flags[i] = cur_ff.sync2[i];
    end
    // Mode selector writable only in the position configuration
    if (!pos_config_in)
      nxt_cur.mode = DVRC_MODE_VEL;
    else if (mode_wr_in)
      nxt_cur.mode = mode_wdata_in;
    if (cmd_wr_in)
      nxt_cur.cw = cmd_wdata_in;
    // Drive state machine, simplified bring-up path
    case (cur_ff.st)
      DVRC_ST_SWDIS:
      begin
        if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_SHUTDOWN[3:0])
          nxt_cur.st = DVRC_ST_READY;
        else if (cmd_wr_in && !pos_config_in
                 && cmd_wdata_in[3:0] == DVRC_CW_ST_MASK)
          nxt_cur.st = DVRC_ST_OPEN;
      end
      DVRC_ST_READY:
      begin
        if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_SWON[3:0])
          nxt_cur.st = DVRC_ST_SWON;
        else if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_ENABLE[3:0])
          nxt_cur.st = DVRC_ST_OPEN;
        else if (cmd_wr_in && cmd_wdata_in[1] == 1'b0)
          nxt_cur.st = DVRC_ST_SWDIS;
      end
      DVRC_ST_SWON:
      begin
        if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_ENABLE[3:0])
          nxt_cur.st = DVRC_ST_OPEN;
        else if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_SHUTDOWN[3:0])
          nxt_cur.st = DVRC_ST_READY;
        else if (cmd_wr_in && cmd_wdata_in[1] == 1'b0)
          nxt_cur.st = DVRC_ST_SWDIS;
      end
      DVRC_ST_OPEN:
      begin
        if (cmd_wr_in && cmd_wdata_in[1] == 1'b0)
          nxt_cur.st = DVRC_ST_SWDIS;
        else if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_SWON[3:0])
          nxt_cur.st = DVRC_ST_SWON;
        else if (cmd_wr_in && cmd_wdata_in[3:0] == DVRC_CW_SHUTDOWN[3:0])
          nxt_cur.st = DVRC_ST_READY;
      end
      default:
      begin
        nxt_cur.st = DVRC_ST_SWDIS;
      end
    endcase
    // A synchronised fault overrides any command of the same cycle
    if (cur_ff.flags[3])
      nxt_cur.st = DVRC_ST_SWDIS;
    // Sign memory follows the last nonzero bus reference
    // Tracked in every source setting so a switch to bus-only starts right
    if (bus_ref_in != DVRC_REF_ZERO)
      nxt_cur.neg_sign = bus_ref_in[DVRC_REF_W-1];
    sgn     = (bus_ref_in == DVRC_REF_ZERO) ? cur_ff.neg_sign : bus_ref_in[DVRC_REF_W-1];
    bus_abs = bus_ref_in[DVRC_REF_W-1] ? -bus_ref_in : bus_ref_in;
    if (bus_abs < mag_min)
      bus_cl = sgn ? -mag_min : mag_min;
    else
      bus_cl = bus_ref_in;
    nxt_cur.int_act = int_ref_in;
    case (ramp_src_in)
      DVRC_SRC_INT:
      begin
        nxt_cur.bus_act  = DVRC_REF_ZERO;
        nxt_cur.ramp_act = int_ref_in;
      end
      DVRC_SRC_BUS:
      begin
        nxt_cur.bus_act  = bus_cl;
        nxt_cur.ramp_act = bus_cl;
      end
      default:
      begin
        // Signed sum carries its own sign
        nxt_cur.bus_act  = bus_ref_in;
        nxt_cur.ramp_act = int_ref_in + bus_ref_in;
      end
    endcase
    // Special source only when enabled and not the zero setting
    use_special = mode_bits_on && (sfg_sel_in != DVRC_SFG_ZERO)
                  && !cur_ff.cw[DVRC_CW_SRCSEL];
    // No reference while disabled, even as the ramp winds down
    if (!op_enabled)
      nxt_cur.speed = DVRC_REF_ZERO;
    else if (use_special && !halt_req)
      nxt_cur.speed = special_ref_in;
    else
      nxt_cur.speed = ramp_value;
    // Report word, unlisted bits stay zero
    // Pin flag bits lag their pins by the synchroniser depth plus two
    nxt_cur.sw = '0;
    nxt_cur.sw[DVRC_SW_RDY]     = (cur_ff.st != DVRC_ST_SWDIS);
    nxt_cur.sw[DVRC_SW_SWON]    = (cur_ff.st == DVRC_ST_SWON) || op_enabled;
    nxt_cur.sw[DVRC_SW_OPEN]    = op_enabled;
    nxt_cur.sw[DVRC_SW_FAULT]   = cur_ff.flags[3];
    nxt_cur.sw[DVRC_SW_VOLT]    = (cur_ff.st != DVRC_ST_SWDIS);
    nxt_cur.sw[DVRC_SW_QSTOP_N] = (cur_ff.st != DVRC_ST_SWDIS);
    nxt_cur.sw[DVRC_SW_SWDIS]   = (cur_ff.st == DVRC_ST_SWDIS);
    nxt_cur.sw[DVRC_SW_WARN]    = cur_ff.flags[2];
    nxt_cur.sw[DVRC_SW_REMOTE]  = remote_in;
    nxt_cur.sw[DVRC_SW_TGT]     = 1'b0;
    nxt_cur.sw[DVRC_SW_LIMIT]   = cur_ff.flags[0];
    nxt_cur.sw[DVRC_SW_WARN2]   = cur_ff.flags[1];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cur_ff          <= '0;
      cur_ff.cw       <= DVRC_CW_RESET;
      cur_ff.mode     <= DVRC_MODE_VEL;
      cur_ff.st       <= DVRC_ST_SWDIS;
      cur_ff.neg_sign <= 1'b0;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign drive_command_word_out      = cur_ff.cw;
  assign drive_state_report_word_out = cur_ff.sw;
  assign operating_mode_selector_out = cur_ff.mode;
  assign int_ref_act_out             = cur_ff.int_act;
  assign bus_ref_act_out             = cur_ff.bus_act;
  assign ramp_in_act_out             = cur_ff.ramp_act;
  assign speed_ref_out               = cur_ff.speed;
endmodule : dvrc_top
`default_nettype wire

/* logic/dvrc_pkg.sv */
// Constants and types for the drive velocity reference control block.
// Assumes a single 125 MHz drive clock and 16-bit command and report words.
package dvrc_pkg;
  localparam int          DVRC_WORD_W      = 16;
  localparam int          DVRC_REF_W       = 24;
  // Ramp setpoint source settings
  localparam logic [1:0]  DVRC_SRC_INT     = 2'h1;
  localparam logic [1:0]  DVRC_SRC_BUS     = 2'h2;
  localparam logic [1:0]  DVRC_SRC_SUM     = 2'h3;
  localparam logic [1:0]  DVRC_SRC_RST     = 2'h3;
  // Operating mode selector
  localparam logic [7:0]  DVRC_MODE_VEL    = 8'h02;
  // Special function generator zero setting
  localparam logic [3:0]  DVRC_SFG_ZERO    = 4'h9;
  // Command word bit positions
  localparam int          DVRC_CW_SRCSEL   = 4;
  localparam int          DVRC_CW_UNLOCK   = 5;
  localparam int          DVRC_CW_USEREF   = 6;
  localparam int          DVRC_CW_HALT     = 8;
  localparam logic [3:0]  DVRC_CW_ST_MASK  = 4'hF;
  // Command word values of the bring-up sequence
  localparam logic [15:0] DVRC_CW_DISABLE  = 16'h0000;
  localparam logic [15:0] DVRC_CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] DVRC_CW_SWON     = 16'h0007;
  localparam logic [15:0] DVRC_CW_ENABLE   = 16'h000F;
  localparam logic [15:0] DVRC_CW_RESET    = 16'h0000;
  // Report word bit positions
  localparam int          DVRC_SW_RDY      = 0;
  localparam int          DVRC_SW_SWON     = 1;
  localparam int          DVRC_SW_OPEN     = 2;
  localparam int          DVRC_SW_FAULT    = 3;
  localparam int          DVRC_SW_VOLT     = 4;
  localparam int          DVRC_SW_QSTOP_N  = 5;
  localparam int          DVRC_SW_SWDIS    = 6;
  localparam int          DVRC_SW_WARN     = 7;
  localparam int          DVRC_SW_REMOTE   = 9;
  localparam int          DVRC_SW_TGT      = 10;
  localparam int          DVRC_SW_LIMIT    = 11;
  localparam int          DVRC_SW_WARN2    = 15;
  localparam logic [23:0] DVRC_REF_ZERO    = 24'h000000;
  // Scale rpm to 0.01 Hz steps: caller supplies pole-pair factor externally
  localparam logic [23:0] DVRC_RATE_RST    = 24'h000001;

  typedef enum logic [3:0]
  {
    DVRC_ST_SWDIS = 4'b0001,
    DVRC_ST_READY = 4'b0010,
    DVRC_ST_SWON  = 4'b0100,
    DVRC_ST_OPEN  = 4'b1000
  } dvrc_state_t;
endpackage : dvrc_pkg

/* logic/dvrc_ramp.sv */
// Ramp generator: moves its output toward a target by a signed step per cycle.
// Assumes the caller picks the rate; freeze holds the output.
`timescale 1ns/100ps
`default_nettype none
module dvrc_ramp
(
  input  wire logic                             clk_sys_in,
  input  wire logic                             rst_in,
  input  wire logic                             run_in,
  input  wire logic signed [dvrc_pkg::DVRC_REF_W-1:0] target_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] rate_up_in,
  input  wire logic        [dvrc_pkg::DVRC_REF_W-1:0] rate_dn_in,
  output var  logic signed [dvrc_pkg::DVRC_REF_W-1:0] value_out
);
  import dvrc_pkg::*;

  typedef struct packed
  {
    logic signed [DVRC_REF_W-1:0] val;
  } dvrc_ramp_t;

  dvrc_ramp_t cur_ff;
  dvrc_ramp_t nxt_cur;

  always_comb
  begin
    logic signed [DVRC_REF_W:0] diff;
    logic        [DVRC_REF_W:0] step;
    logic        [DVRC_REF_W:0] mag;
    diff    = '0;
    step    = '0;
    mag     = '0;
    nxt_cur = cur_ff;
    if (run_in)
    begin
      diff = {target_in[DVRC_REF_W-1], target_in} - {cur_ff.val[DVRC_REF_W-1], cur_ff.val};
      mag  = diff[DVRC_REF_W] ? (DVRC_REF_W+1)'(-diff) : diff;
      // Leaving standstill or moving away from zero accelerates
      if ((cur_ff.val == 0) || ((cur_ff.val >= 0) == (diff >= 0)))
        step = {1'b0, rate_up_in};
      else
        step = {1'b0, rate_dn_in};
      if (mag <= step)
        nxt_cur.val = target_in;
      else if (diff[DVRC_REF_W])
        nxt_cur.val = cur_ff.val - DVRC_REF_W'(step);
      else
        nxt_cur.val = cur_ff.val + DVRC_REF_W'(step);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      cur_ff <= '{val: DVRC_REF_ZERO};
    else
      cur_ff <= nxt_cur;
  end

  assign value_out = cur_ff.val;
endmodule : dvrc_ramp
`default_nettype wire

/* dv/dvrc_top_asserts.sv */
// Concurrent checks on the velocity reference control top level.
// Assumes it is bound to dvrc_top and that one clock and one reset serve all.
`timescale 1ns/100ps
`default_nettype none
module dvrc_top_asserts
(
  input wire logic               clk_sys_in,
  input wire logic               rst_in,
  input wire logic               cmd_wr_in,
  input wire logic [15:0]        cmd_wdata_in,
  input wire logic               pos_config_in,
  input wire logic               remote_in,
  input wire logic [1:0]         ramp_src_in,
  input wire logic [23:0]        min_freq_in,
  input wire logic               fault_pin_in,
  input wire logic               limit_pin_in,
  input wire logic               second_warning_flag_pin_in,
  input wire logic [15:0]        drive_command_word_out,
  input wire logic [15:0]        drive_state_report_word_out,
  input wire logic [7:0]         operating_mode_selector_out,
  input wire logic signed [23:0] int_ref_act_out,
  input wire logic signed [23:0] bus_ref_act_out,
  input wire logic signed [23:0] ramp_in_act_out
);
  import dvrc_pkg::*;
  logic        [1:0]  up_ff;
  logic signed [24:0] bus_mag;
  // Report word is 0 at the first edge, so skip early cycles
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  always_comb
    bus_mag = (bus_ref_act_out < 0) ? -25'(bus_ref_act_out) : 25'(bus_ref_act_out);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_cmd; cmd_wr_in |=> drive_command_word_out == $past(cmd_wdata_in); endproperty
  a_cmd: assert property (p_cmd) else $error("command word not stored");
  property p_rsv; drive_state_report_word_out[14:12] == 3'h0 && !drive_state_report_word_out[8];
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused report bits set");
  property p_tgt; !drive_state_report_word_out[10]; endproperty
  a_tgt: assert property (p_tgt) else $error("target bit set in velocity mode");
  property p_mode; !pos_config_in && !$past(pos_config_in) |->
    operating_mode_selector_out == DVRC_MODE_VEL; endproperty
  a_mode: assert property (p_mode) else $error("mode selector left velocity");
  property p_clamp; ramp_src_in == DVRC_SRC_BUS |=> bus_mag >= 25'($past(min_freq_in));
  endproperty
  a_clamp: assert property (p_clamp) else $error("bus reference below minimum");
  property p_sum; ramp_src_in == DVRC_SRC_SUM && $past(ramp_src_in) == DVRC_SRC_SUM |->
    ramp_in_act_out == int_ref_act_out + bus_ref_act_out; endproperty
  a_sum: assert property (p_sum) else $error("ramp input is not the sum");
  property p_rem; up_ff == 2'h3 && $stable(remote_in) && $past(remote_in) == $past(remote_in, 2)
    |-> drive_state_report_word_out[9] == remote_in; endproperty
  a_rem: assert property (p_rem) else $error("remote bit wrong");
  property p_fault; $rose(fault_pin_in) |-> ##[1:10] drive_state_report_word_out[3]; endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_limit; $rose(limit_pin_in) |-> ##[1:10] drive_state_report_word_out[11]; endproperty
  a_limit: assert property (p_limit) else $error("limit not reported");
  property p_warn2; $rose(second_warning_flag_pin_in) |->
    ##[1:10] drive_state_report_word_out[15]; endproperty
  a_warn2: assert property (p_warn2) else $error("second warning not reported");
  c_en: cover property (drive_state_report_word_out[7:0] == 8'h37);
  c_halt: cover property (drive_command_word_out[8] && drive_state_report_word_out[2]);
  c_neg: cover property (ramp_src_in == DVRC_SRC_BUS && bus_ref_act_out < 0);
endmodule : dvrc_top_asserts
bind dvrc_top dvrc_top_asserts i_chk (.*);
`default_nettype wire

/* dv/dvrc_plc_model.sv */
// Fieldbus controller model: writes command words, polls the report word.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module dvrc_plc_model
(
  input  wire logic        clk_sys_in,
  input  wire logic [15:0] report_in,
  output var  logic        cmd_wr_out,
  output var  logic [15:0] cmd_wdata_out
);
  initial
  begin
    cmd_wr_out = 1'b0;
    cmd_wdata_out = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    cmd_wr_out = 1'b1;
    cmd_wdata_out = w;
    @(posedge clk_sys_in);
    #1;
    cmd_wr_out = 1'b0;
    // Released data lines carry junk, never the last word
    cmd_wdata_out = ~w;
    @(posedge clk_sys_in);
    #1;
  endtask : send
  task automatic await(input int bit_no);
    int n;
    n = 0;
    while (report_in[bit_no] !== 1'b1 && n < 12)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask : await
  task automatic bring_up(input logic short_seq);
    send(16'h0000);
    await(6);
    if (!short_seq)
    begin
      send(16'h0006);
      await(0);
      send(16'h0007);
      await(1);
    end
    send(16'h000F);
    await(2);
  endtask : bring_up
endmodule : dvrc_plc_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the velocity reference control block.
// Assumes the package, the controller model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dvrc_pkg::*;
  typedef struct {int sel; logic [23:0] v;} dvrc_note_t;
  logic               clk, rst, mwr, pcfg, rem, fpin, wpin, w2pin, lpin, cwr, neg;
  logic        [7:0]  mdat, mode;
  logic        [1:0]  src;
  logic        [3:0]  sfg;
  logic signed [23:0] iref, bref, tgt, sref, ia, ba, ra, spd;
  logic        [23:0] fmin, acc, dec, mag, e;
  logic        [15:0] cdat, cw, sw, seed;
  int                 failures, cmp_count;
  dvrc_note_t         q[$];
  dvrc_note_t         nt;
  string              nms [7] = '{"report", "command", "mode", "int", "bus", "ramp_in", "speed"};
  dvrc_top i_dut
  (
    .clk_sys_in(clk), .rst_in(rst), .cmd_wr_in(cwr), .cmd_wdata_in(cdat),
    .mode_wr_in(mwr), .mode_wdata_in(mdat), .pos_config_in(pcfg), .remote_in(rem),
    .ramp_src_in(src), .sfg_sel_in(sfg), .int_ref_in(iref), .bus_ref_in(bref),
    .bus_target_speed_in(tgt), .special_ref_in(sref), .min_freq_in(fmin),
    .acc_cw_in(acc), .acc_acw_in(acc), .dec_cw_in(dec), .dec_acw_in(dec << 1),
    .fault_pin_in(fpin), .warn_pin_in(wpin), .second_warning_flag_pin_in(w2pin),
    .limit_pin_in(lpin), .drive_command_word_out(cw), .drive_state_report_word_out(sw),
    .operating_mode_selector_out(mode), .int_ref_act_out(ia), .bus_ref_act_out(ba),
    .ramp_in_act_out(ra), .speed_ref_out(spd)
  );
  dvrc_plc_model i_plc
  (
    .clk_sys_in(clk), .report_in(sw), .cmd_wr_out(cwr), .cmd_wdata_out(cdat)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [23:0] seen(input int s);
    case (s)
      0: return {8'h00, sw};
      1: return {8'h00, cw};
      2: return {16'h0000, mode};
      3: return ia;
      4: return ba;
      5: return ra;
      default: return spd;
    endcase
  endfunction : seen
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic note(input int s, input logic [23:0] v);
    q.push_back('{s, v});
  endtask : note
  // Bounded wait: a stuck ramp still ends in a mismatch
  task automatic ramp_to(input logic [23:0] v);
    int k;
    k = 0;
    while (spd !== v && k < 300)
    begin
      tick();
      k++;
    end
    note(6, v);
  endtask : ramp_to
  task automatic mode_write(input logic [7:0] v);
    mdat = v;
    mwr = 1'b1;
    tick();
    mwr = 1'b0;
    tick(2);
  endtask : mode_write
  task automatic complete_run();
    $display("Counts: %0d compared, %0d failed", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial
  begin
    forever
    begin
      wait (q.size() > 0);
      nt = q.pop_front();
      check(nms[nt.sel], seen(nt.sel), nt.v);
    end
  end
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end
  initial
  begin
    rst = 1'b1;
    {mwr, pcfg, rem, fpin, wpin, w2pin, lpin, neg} = '0;
    {mdat, sfg, iref, bref, tgt, sref} = '0;
    src = DVRC_SRC_BUS;
    fmin = 24'h000100;
    acc = 24'h000040;
    dec = 24'h000020;
    seed = 16'h0015;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(4);
    note(0, 24'h000040);
    note(1, 24'h000000);
    note(2, 24'h000002);
    note(6, 24'h000000);
    note(4, 24'h000100);
    $display("Test reset done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      bref = i[0] ? 24'sh0 : $signed({{14{seed[9]}}, seed[9:0]});
      if (i == 6)
        bref = -24'sh10;
      // Second minimum setting half way through
      if (i == 4)
        fmin = 24'h000180;
      if (bref != 0)
        neg = bref[23];
      mag = bref[23] ? -bref : bref;
      e = (mag < fmin) ? (neg ? -fmin : fmin) : bref;
      tick(2);
      note(4, e);
    end
    $display("Test clamp done");
    src = DVRC_SRC_INT;
    seed = lfsr(seed);
    iref = $signed({{12{seed[11]}}, seed[11:0]});
    tick(2);
    note(3, iref);
    note(4, 24'h000000);
    note(5, iref);
    src = DVRC_SRC_SUM;
    iref = -24'sh500;
    bref = 24'sh200;
    tick(2);
    note(5, -24'sh300);
    $display("Test sources done");
    rem = 1'b1;
    i_plc.bring_up(1'b1);
    tick(2);
    note(0, 24'h000237);
    note(1, 24'h00000F);
    ramp_to(-24'sh300);
    mode_write(8'h03);
    note(2, 24'h000002);
    $display("Test short bring-up done");
    pcfg = 1'b1;
    rem = 1'b0;
    i_plc.bring_up(1'b1);
    tick(2);
    note(0, 24'h000040);
    i_plc.await(6);
    mode_write(8'h03);
    note(2, 24'h000003);
    mode_write(8'h02);
    note(2, 24'h000002);
    i_plc.bring_up(1'b0);
    tick(2);
    note(0, 24'h000037);
    $display("Test full bring-up done");
    tgt = 24'sh400;
    i_plc.send(16'h007F);
    ramp_to(24'h000400);
    sfg = 4'h1;
    sref = 24'sh123;
    i_plc.send(16'h006F);
    ramp_to(24'h000123);
    sfg = DVRC_SFG_ZERO;
    ramp_to(24'h000400);
    i_plc.send(16'h005F);
    tgt = 24'sh100;
    tick(20);
    note(6, 24'h000400);
    i_plc.send(16'h003F);
    ramp_to(24'h000000);
    tgt = 24'sh400;
    acc = 24'h000080;
    i_plc.send(16'h007F);
    ramp_to(24'h000400);
    // Halt acts one edge after the word lands; speed lags the ramp by one
    dec = 24'h000030;
    i_plc.send(16'h017F);
    tick(5);
    note(6, 24'h000400 - 24'(5 * dec));
    ramp_to(24'h000000);
    note(0, 24'h000037);
    $display("Test motion done");
    {lpin, w2pin, wpin} = 3'b111;
    tick(12);
    note(0, 24'h0088B7);
    fpin = 1'b1;
    tick(12);
    note(0, 24'h0088C8);
    {fpin, lpin, w2pin, wpin} = 4'h0;
    tick(6);
    note(0, 24'h000040);
    tick();
    $display("Test pins done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
